// file: core/cct_timer.sv
/*
 Two-channel 16-bit capture/compare timer with an APB register slave.
 Assumes pins arrive asynchronously and APB masters follow the protocol.
*/
`timescale 1ns/10ps
`default_nettype none
module cct_timer (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [cct_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [1:0] channel_pin_in,
   output logic [1:0] channel_pin_out,
   output logic [1:0] channel_pin_oe,
   output logic overflow_irq,
   output logic [1:0] channel_irq
);
   import cct_pkg::*;

   typedef struct packed {
      logic overflow_flag;
      logic tof_arm;
      logic overflow_irq_enable;
      logic halt;
      logic [2:0] ps;
      logic [15:0] count;
      logic [15:0] modv;
      logic mod_inh;
      logic latched;
      logic [7:0] cnt_buf;
      logic bufm;
      logic active;
      logic bpend;
      logic [1:0] chf;
      logic [1:0] arm;
      logic [1:0] chie;
      logic [1:0] msa;
      logic [1:0][1:0] els;
      logic [1:0] tov;
      logic [1:0][15:0] val;
      logic [1:0] cmp_inh;
      logic [1:0] cap_inh;
      logic [1:0] pin_q1;
      logic [1:0] pin_q2;
      logic [1:0] pin_q3;
      logic [1:0] pout;
      logic [7:0] rdata;
   } cct_state_s;

   cct_state_s st;
   cct_state_s next_st;
   logic tick;
   logic acc;
   logic wr;
   logic setup_rd;
   logic hit;
   logic clr_wr;
   logic ovf;
   logic [7:0] wb;
   logic [1:0] en;
   logic [1:0] capt;
   logic [1:0] cmpm;
   logic [1:0] rise;
   logic [1:0] fall;
   logic [1:0] cap_ev;
   logic [1:0] cmp_ev;
   logic [1:0] inh;
   logic [1:0][15:0] cval;
   logic [1:0][7:0] sc_byte;

   // The prescaler is frozen with the counter, so a halted timer
   // resumes mid-period rather than restarting the divide.
   cct_prescaler u_pre (
      .clock(clock),
      .reset_n(reset_n),
      .run(~st.halt),
      .clear(clr_wr),
      .select(st.ps),
      .tick(tick)
   );

   always_comb begin
      acc = psel & penable;
      wr = acc & pwrite;
      setup_rd = psel & ~penable & ~pwrite;
      wb = pwdata[7:0];
      hit = (paddr <= OFS_LAST) && (paddr[1:0] == 2'h0);
      clr_wr = wr && (paddr == OFS_TSC) && wb[TSC_CLR];
      ovf = tick && (st.count == st.modv);

      for (int i = 0; i < 2; i++) begin
         // Channel one is taken over by channel zero in buffered mode.
         en[i] = !(i == 1 && st.bufm);
         capt[i] = en[i] && st.els[i] != ELS_OFF && !st.msa[i]
            && !(i == 0 && st.bufm);
         cmpm[i] = en[i] && st.els[i] != ELS_OFF
            && (st.msa[i] || (i == 0 && st.bufm));
         cval[i] = (i == 0 && st.bufm) ? st.val[st.active] : st.val[i];
         inh[i] = (i == 0 && st.bufm) ? st.cmp_inh[st.active]
            : st.cmp_inh[i];
         rise[i] = st.pin_q2[i] & ~st.pin_q3[i];
         fall[i] = ~st.pin_q2[i] & st.pin_q3[i];
         cap_ev[i] = capt[i] && !st.cap_inh[i]
            && ((st.els[i][0] && rise[i]) || (st.els[i][1] && fall[i]));
         cmp_ev[i] = cmpm[i] && tick && !inh[i]
            && (st.count == cval[i]);
         sc_byte[i] = {st.chf[i], st.chie[i], (i == 0) && st.bufm,
            st.msa[i], st.els[i], st.tov[i], 1'b0};
         if (!en[i]) begin
            sc_byte[i] = 8'h00;
         end
      end

      next_st = st;
      next_st.pin_q1 = channel_pin_in;
      next_st.pin_q2 = st.pin_q1;
      next_st.pin_q3 = st.pin_q2;

      // Read data and read side effects are taken in the setup cycle so
      // that the byte returned and the byte latched come from one count.
      next_st.rdata = 8'h00;
      if (setup_rd) begin
         if (paddr == OFS_TSC) begin
            next_st.rdata = {st.overflow_flag, st.overflow_irq_enable, st.halt, 2'b00, st.ps};
            if (st.overflow_flag) begin
               next_st.tof_arm = 1'b1;
            end
         end
         if (paddr == OFS_CNTH) begin
            next_st.rdata = st.count[15:8];
            if (!st.latched) begin
               next_st.latched = 1'b1;
               next_st.cnt_buf = st.count[7:0];
            end
         end
         if (paddr == OFS_CNTL) begin
            next_st.rdata = st.latched ? st.cnt_buf : st.count[7:0];
            next_st.latched = 1'b0;
         end
         if (paddr == OFS_MODH) begin
            next_st.rdata = st.modv[15:8];
         end
         if (paddr == OFS_MODL) begin
            next_st.rdata = st.modv[7:0];
         end
         for (int i = 0; i < 2; i++) begin
            if (paddr == OFS_SC[i]) begin
               next_st.rdata = sc_byte[i];
               if (st.chf[i] && en[i]) begin
                  next_st.arm[i] = 1'b1;
               end
            end
            if (paddr == OFS_VH[i]) begin
               next_st.rdata = st.val[i][15:8];
               if (capt[i]) begin
                  next_st.cap_inh[i] = 1'b1;
               end
            end
            if (paddr == OFS_VL[i]) begin
               next_st.rdata = st.val[i][7:0];
               next_st.cap_inh[i] = 1'b0;
            end
         end
      end

      // Software writes come first; hardware events below override them.
      if (wr) begin
         if (paddr == OFS_TSC) begin
            next_st.overflow_irq_enable = wb[TSC_OVERFLOW_IRQ_ENABLE];
            next_st.halt = wb[TSC_HALT];
            // The unavailable divide code is refused and the old one kept.
            if (wb[2:0] != PS_NONE) begin
               next_st.ps = wb[2:0];
            end
            if (!wb[TSC_TOF] && st.tof_arm) begin
               next_st.overflow_flag = 1'b0;
            end
            next_st.tof_arm = 1'b0;
         end
         if (paddr == OFS_MODH) begin
            next_st.modv[15:8] = wb;
            next_st.mod_inh = 1'b1;
         end
         if (paddr == OFS_MODL) begin
            next_st.modv[7:0] = wb;
            next_st.mod_inh = 1'b0;
         end
         for (int i = 0; i < 2; i++) begin
            if (paddr == OFS_SC[i] && en[i]) begin
               next_st.chie[i] = wb[CH_IE];
               next_st.msa[i] = wb[CH_MSA];
               next_st.els[i] = wb[CH_ELSB:CH_ELSA];
               next_st.tov[i] = wb[CH_TOV];
               if (i == 0) begin
                  next_st.bufm = wb[CH_MSB];
               end
               if (!wb[CH_FLAG] && st.arm[i]) begin
                  next_st.chf[i] = 1'b0;
               end
               next_st.arm[i] = 1'b0;
            end
            if (paddr == OFS_VH[i]) begin
               next_st.val[i][15:8] = wb;
               next_st.cmp_inh[i] = 1'b1;
            end
            if (paddr == OFS_VL[i]) begin
               next_st.val[i][7:0] = wb;
               next_st.cmp_inh[i] = 1'b0;
               if (st.bufm && (i != int'(st.active))) begin
                  next_st.bpend = 1'b1;
               end
            end
         end
      end

      // Counter: clear beats rollover, rollover beats increment.
      if (clr_wr) begin
         next_st.count = COUNT_ZERO;
         next_st.latched = 1'b0;
         next_st.cnt_buf = 8'h00;
      end else if (ovf) begin
         next_st.count = COUNT_ZERO;
      end else if (tick) begin
         next_st.count = st.count + 16'h0001;
      end

      // A set in the same cycle as a clear wins, so no event is lost.
      if (ovf && !st.mod_inh) begin
         next_st.overflow_flag = 1'b1;
         next_st.tof_arm = 1'b0;
      end

      // In buffered mode the other channel's value is taken at the first rollover after its low byte is written.
      if (!st.bufm) begin
         next_st.active = 1'b0;
         next_st.bpend = 1'b0;
      end else if (ovf && st.bpend) begin
         next_st.active = ~st.active;
         next_st.bpend = 1'b0;
      end

      for (int i = 0; i < 2; i++) begin
         if (cap_ev[i]) begin
            next_st.val[i] = st.count;
         end
         if (cap_ev[i] || cmp_ev[i]) begin
            next_st.chf[i] = 1'b1;
            next_st.arm[i] = 1'b0;
         end
         if (st.els[i] == ELS_OFF) begin
            next_st.pout[i] = ~st.msa[i];
         end else if (cmpm[i]) begin
            if (ovf && st.tov[i]) begin
               next_st.pout[i] = ~st.pout[i];
            end else if (cmp_ev[i]) begin
               unique case (st.els[i])
                  ELS_TOGGLE: next_st.pout[i] = ~st.pout[i];
                  ELS_LOW: next_st.pout[i] = 1'b0;
                  ELS_HIGH: next_st.pout[i] = 1'b1;
                  default: next_st.pout[i] = st.pout[i];
               endcase
            end
         end
      end

      // Pins outside compare mode are left to the port logic.
      channel_pin_oe = cmpm;
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         st <= '0;
         st.halt <= HALT_RST;
         st.modv <= MOD_RST;
      end else begin
         st <= next_st;
      end
   end

   assign prdata = {24'h000000, st.rdata};
   assign pready = 1'b1;
   assign pslverr = acc & ~hit;
   assign channel_pin_out = st.pout;
   assign overflow_irq = st.overflow_flag & st.overflow_irq_enable;
   assign channel_irq = st.chf & st.chie & en;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   sequence s_stopped_zero;
      (st.count == COUNT_ZERO && st.halt) [*2];
   endsequence

   sequence s_rolled;
      st.overflow_flag && st.count == COUNT_ZERO;
   endsequence

   AST_HALT_HOLDS: assert property (st.halt && !clr_wr |=> $stable(st.count))
      else $error("Counter moved while halted.");

   AST_CLEAR_ZEROES: assert property (clr_wr |=> st.count == COUNT_ZERO && !st.latched)
      else $error("Clear strobe did not zero the counter.");

   AST_HALT_CLEAR: assert property (clr_wr && wb[TSC_HALT] |=> s_stopped_zero)
      else $error("Halt with clear did not stop at zero.");

   AST_LATCH_LOW: assert property (setup_rd && paddr == OFS_CNTH && !st.latched
      ##1 (!setup_rd && !clr_wr) [*2] ##1 setup_rd && paddr == OFS_CNTL
      |=> st.rdata == $past(st.cnt_buf))
      else $error("Low byte read did not return the latched value.");

   AST_OVERFLOW: assert property (ovf && !st.mod_inh && !clr_wr |=> s_rolled)
      else $error("Overflow did not set the flag and wrap to zero.");

   AST_MOD_INHIBIT: assert property (st.mod_inh && !st.overflow_flag |=> !st.overflow_flag)
      else $error("Overflow flag set while the limit was half written.");

   AST_CAPTURE: assert property (cap_ev[1] |=> st.chf[1] && st.val[1] == $past(st.count))
      else $error("Capture edge did not flag and store the count.");

   AST_FLAG_SET_WINS: assert property (cmp_ev[1] || cap_ev[1] |=> st.chf[1])
      else $error("Channel event was lost against a clear.");

   AST_IRQ_GATE: assert property (st.chf[1] && !st.chie[1] |-> !channel_irq[1])
      else $error("Channel request raised while disabled.");

   AST_BUF_RELEASE: assert property (st.bufm |-> !channel_pin_oe[1] && sc_byte[1] == 8'h00)
      else $error("Channel one still active in buffered mode.");

   AST_GPIO: assert property (st.els[0] == ELS_OFF |-> !channel_pin_oe[0])
      else $error("Pin driven with edge field off.");

   AST_ROLL_WINS: assert property (ovf && cmpm[0] && st.tov[0]
      |=> channel_pin_out[0] != $past(channel_pin_out[0]))
      else $error("Rollover toggle lost to compare.");

   AST_CMP_INHIBIT: assert property (st.cmp_inh[0] && !st.bufm |-> !cmp_ev[0])
      else $error("Compare fired while the value was half written.");

   AST_COUNT_STEP: assert property (tick && !ovf && !clr_wr
      |=> st.count == $past(st.count) + 16'h0001)
      else $error("Counter did not step by one on a tick.");
endmodule // cct_timer
`default_nettype wire

// file: common/cct_pkg.sv
/*
 Constants shared by the capture/compare timer: register offsets, field
 positions, reset values and channel mode encodings.
 Assumes an APB bus with byte-wide registers, one per aligned word.
*/
package cct_pkg;
   localparam int ADDR_W = 8;
   localparam int PRE_W = 6;
   localparam logic [7:0] OFS_TSC = 8'h00;
   localparam logic [7:0] OFS_CNTH = 8'h04;
   localparam logic [7:0] OFS_CNTL = 8'h08;
   localparam logic [7:0] OFS_MODH = 8'h0C;
   localparam logic [7:0] OFS_MODL = 8'h10;
   localparam logic [1:0][7:0] OFS_SC = {8'h20, 8'h14};
   localparam logic [1:0][7:0] OFS_VH = {8'h24, 8'h18};
   localparam logic [1:0][7:0] OFS_VL = {8'h28, 8'h1C};
   localparam logic [7:0] OFS_LAST = 8'h28;
   localparam int TSC_TOF = 7;
   localparam int TSC_OVERFLOW_IRQ_ENABLE = 6;
   localparam int TSC_HALT = 5;
   localparam int TSC_CLR = 4;
   localparam int CH_FLAG = 7;
   localparam int CH_IE = 6;
   localparam int CH_MSB = 5;
   localparam int CH_MSA = 4;
   localparam int CH_ELSB = 3;
   localparam int CH_ELSA = 2;
   localparam int CH_TOV = 1;
   localparam logic [2:0] PS_NONE = 3'h7;
   localparam logic HALT_RST = 1'b1;
   localparam logic [15:0] MOD_RST = 16'hFFFF;
   localparam logic [15:0] COUNT_ZERO = 16'h0000;
   localparam logic [1:0] ELS_OFF = 2'h0;
   localparam logic [1:0] ELS_TOGGLE = 2'h1;
   localparam logic [1:0] ELS_LOW = 2'h2;
   localparam logic [1:0] ELS_HIGH = 2'h3;
endpackage

// file: core/cct_prescaler.sv
/*
 Prescaler for the capture/compare timer: a free counter that yields a
 one-cycle tick every 2**select bus clocks.
 Assumes select is never the unavailable code; the register refuses it.
*/
`timescale 1ns/10ps
`default_nettype none
module cct_prescaler #(
   parameter int W = cct_pkg::PRE_W
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic run,
   input wire logic clear,
   input wire logic [2:0] select,
   output logic tick
);
   import cct_pkg::*;
   typedef struct packed {
      logic [W-1:0] cnt;
   } cct_pre_s;
   cct_pre_s st;
   cct_pre_s next_st;
   logic [W-1:0] mask;

   always_comb begin
      for (int k = 0; k < W; k++) begin
         mask[k] = (k < int'(select));
      end
      // The tick fires when all selected low bits are ones.
      tick = run & ~clear & (&(st.cnt | ~mask));
      next_st = st;
      if (clear) begin
         next_st.cnt = '0;
      end else if (run) begin
         next_st.cnt = st.cnt + 1'b1;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   AST_TICK_DIV1: assert property (@(posedge clock) disable iff (!reset_n)
      (select == 3'h0 && run && !clear) |-> tick)
      else $error("Divide-by-one prescaler failed to tick.");
endmodule // cct_prescaler
`default_nettype wire

// file: testbench/cct_pin_model.sv
/*
 External source for the two timer channel pins.
 Assumes the bench sets the level that the outside world drives.
*/
`timescale 1ns/10ps
`default_nettype none
module cct_pin_model (
   input wire logic [1:0] level,
   input wire logic [1:0] pin_out,
   input wire logic [1:0] pin_oe,
   output logic [1:0] pin_in
);
   // A driven pin reads back its own level, so capture cannot see the outside source then.
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & level);
endmodule // cct_pin_model
`default_nettype wire

// file: testbench/cct_timer_bench.sv
/*
 Self-checking bench for the capture/compare timer, driven over APB.
 Assumes the pin model stands for the outside world on the channel pins.
*/
`timescale 1ns/10ps
`default_nettype none
module cct_timer_bench;
   import cct_pkg::*;
   logic clock, reset_n, psel, penable, pwrite, pready, pslverr, ov_irq, er;
   logic [7:0] paddr, q, l1, cfg;
   logic [31:0] pwdata, prdata;
   logic [1:0] lvl, pin_in, pin_out, pin_oe, ch_irq;
   int bad_count, tests_run;
   cct_timer dut (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .channel_pin_in(pin_in), .channel_pin_out(pin_out), .channel_pin_oe(pin_oe),
      .overflow_irq(ov_irq), .channel_irq(ch_irq));
   cct_pin_model pins (.level(lvl), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   task automatic end_of_test;
      if (bad_count == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk1(input string n, input logic e, input logic g);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      // Read data stand through the access cycle, so they are taken at the completing edge.
      q = prdata[7:0];
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      chk8($sformatf("register %h", a), e, q);
   endtask
   task automatic halt_clear(input logic [7:0] ps);
      wr(OFS_TSC, 8'h30 | ps);
   endtask
   task automatic run_span(input int n, input logic [7:0] timer_control_status);
      wr(OFS_TSC, timer_control_status);
      tick(n);
      wr(OFS_TSC, timer_control_status | 8'h20);
   endtask
   initial begin
      reset_n = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, lvl} = '0;
      bad_count = 0;
      tests_run = 0;
      tick(4);
      reset_n <= 1'b1;
      rd(OFS_TSC, 8'h20);
      rd(OFS_MODH, 8'hFF);
      rd(OFS_MODL, 8'hFF);
      tick(10);
      rd(OFS_CNTL, 8'h00);
      chk1("pin0 preset", 1'b1, pin_out[0]);
      chk1("pin0 enable", 1'b0, pin_oe[0]);
      wr(OFS_TSC, 8'h23);
      wr(OFS_TSC, 8'h27);
      rd(OFS_TSC, 8'h23);
      for (int c = 0; c < 7; c++) begin
         halt_clear(8'(c));
         run_span(128, 8'(c));
         apb(1'b0, OFS_CNTL, 8'h00);
         chk1("count per divider", 1'b1, (int'(q) + 1 >= (130 >> c)) && (int'(q) <= (130 >> c) + 1));
      end
      halt_clear(8'h00);
      rd(OFS_CNTL, 8'h00);
      rd(OFS_TSC, 8'h20);
      rd(OFS_MODL, 8'hFF);
      wr(OFS_TSC, 8'h00);
      rd(OFS_CNTH, 8'h00);
      tick(20);
      rd(OFS_CNTH, 8'h00);
      tick(20);
      wr(OFS_TSC, 8'h20);
      apb(1'b0, OFS_CNTL, 8'h00);
      l1 = q;
      apb(1'b0, OFS_CNTH, 8'h00);
      apb(1'b0, OFS_CNTL, 8'h00);
      chk1("latched low byte", 1'b1, q - l1 >= 8'd40);
      halt_clear(8'h00);
      wr(OFS_MODH, 8'h00);
      run_span(300, 8'h00);
      rd(OFS_TSC, 8'h20);
      halt_clear(8'h00);
      wr(OFS_MODL, 8'h05);
      run_span(20, 8'h40);
      rd(OFS_TSC, 8'hE0);
      chk1("overflow request", 1'b1, ov_irq);
      apb(1'b0, OFS_CNTL, 8'h00);
      chk1("count wraps at limit", 1'b1, q <= 8'h05);
      wr(OFS_TSC, 8'hE0);
      rd(OFS_TSC, 8'hE0);
      wr(OFS_TSC, 8'h60);
      rd(OFS_TSC, 8'h60);
      chk1("overflow request off", 1'b0, ov_irq);
      halt_clear(8'h00);
      wr(OFS_MODL, 8'h00);
      wr(OFS_TSC, 8'h00);
      rd(OFS_TSC, 8'h80);
      wr(OFS_TSC, 8'h00);
      rd(OFS_TSC, 8'h80);
      halt_clear(8'h00);
      wr(OFS_MODH, 8'hFF);
      wr(OFS_MODL, 8'hFF);
      wr(OFS_VH[0], 8'h00);
      wr(OFS_VL[0], 8'h03);
      // Actions low, high, toggle, toggle; each span holds exactly one match.
      for (int i = 0; i < 4; i++) begin
         cfg = 8'h50 | (i == 0 ? 8'h08 : i == 1 ? 8'h0C : 8'h04);
         halt_clear(8'h00);
         wr(OFS_SC[0], cfg);
         run_span(10, 8'h00);
         chk1("compare pin", i[0], pin_out[0]);
         chk1("compare enable", 1'b1, pin_oe[0]);
         chk1("channel request", 1'b1, ch_irq[0]);
         rd(OFS_SC[0], cfg | 8'h80);
         wr(OFS_SC[0], cfg | 8'h80);
         rd(OFS_SC[0], cfg | 8'h80);
         wr(OFS_SC[0], cfg);
         rd(OFS_SC[0], cfg);
      end
      halt_clear(8'h00);
      wr(OFS_VH[0], 8'h00);
      run_span(10, 8'h00);
      rd(OFS_SC[0], 8'h54);
      wr(OFS_SC[0], 8'h10);
      tick(2);
      chk1("preset low", 1'b0, pin_out[0]);
      chk1("released pin", 1'b0, pin_oe[0]);
      // Limit and match coincide; clear-on-compare would leave the pin low.
      halt_clear(8'h00);
      wr(OFS_MODH, 8'h00);
      wr(OFS_MODL, 8'h05);
      wr(OFS_VH[0], 8'h00);
      wr(OFS_VL[0], 8'h05);
      wr(OFS_SC[0], 8'h1A);
      run_span(6, 8'h00);
      chk1("rollover beats compare", 1'b1, pin_out[0]);
      for (int e = 1; e < 4; e++) begin
         for (int r = 0; r < 2; r++) begin
            cfg = 8'(e << 2);
            wr(OFS_SC[1], cfg);
            @(posedge clock) lvl[1] <= ~r[0];
            tick(6);
            apb(1'b0, OFS_SC[1], 8'h00);
            wr(OFS_SC[1], cfg);
            @(posedge clock) lvl[1] <= r[0];
            tick(6);
            rd(OFS_SC[1], cfg | ((r ? e[0] : e[1]) ? 8'h80 : 8'h00));
            chk1("capture enable", 1'b0, pin_oe[1]);
         end
      end
      wr(OFS_SC[1], 8'h44);
      @(posedge clock) lvl[1] <= 1'b0;
      tick(6);
      @(posedge clock) lvl[1] <= 1'b1;
      tick(6);
      chk1("channel1 request", 1'b1, ch_irq[1]);
      wr(OFS_SC[0], 8'h20);
      rd(OFS_SC[1], 8'h00);
      wr(OFS_SC[1], 8'h54);
      rd(OFS_SC[1], 8'h00);
      chk1("channel1 pin", 1'b0, pin_oe[1]);
      chk1("channel1 masked", 1'b0, ch_irq[1]);
      // Match at five toggles low, then the second value takes over and toggles back at two.
      halt_clear(8'h00);
      wr(OFS_VH[1], 8'h00);
      wr(OFS_VL[1], 8'h02);
      wr(OFS_SC[0], 8'h24);
      run_span(8, 8'h00);
      chk1("buffered enable", 1'b1, pin_oe[0]);
      chk1("buffered compare pin", 1'b1, pin_out[0]);
      apb(1'b0, 8'h2C, 8'h00);
      chk1("unmapped error", 1'b1, er);
      chk8("unmapped data", 8'h00, q);
      end_of_test;
   end
   initial begin
      tick(30000);
      bad_count++;
      end_of_test;
   end
endmodule // cct_timer_bench
`default_nettype wire
